// [src/lfct_pkg.sv]
// Purpose: Shared constants for the oscillator calibration scheduler and timer block
// Assumes: core_clk at 100 MHz; all low rates come from one-cycle enables
// Notes: Times are kept in their own unit; cycle counts are derived from them
package lfct_pkg;
    localparam int CORE_CLK_HZ = 100_000_000;
    // Nominal low-frequency oscillator rate, in Hz
    localparam int LF_OSC_MHZ_X1000 = 32_768;
    // One tick of the oscillator in core cycles (rounded down, at least one)
    localparam int LF_TICK_CYC = (CORE_CLK_HZ / 1000) * 1000 / LF_OSC_MHZ_X1000 * 1000 / 1000;
    // Time base units expressed in oscillator ticks
    localparam int BASE_US = 488;
    localparam int BASE_LF_TICKS = 16;      // 16 ticks of 32.768 kHz = 488.28 us
    localparam int TMO_US = 976;
    localparam int TMO_BASE_UNITS = 2;      // 976 us = two base units
    localparam int MS_BASE_UNITS = 2;       // One tick count is two base units (976 us)
    // Calibration run length and interval
    localparam int CAL_RUN_MS = 33;
    localparam int CAL_RUN_CYC = CAL_RUN_MS * (CORE_CLK_HZ / 1000);
    localparam int QSEC_MS = 250;
    localparam int QSEC_CYC = QSEC_MS * (CORE_CLK_HZ / 1000);
    localparam logic [6:0] CAL_IVL_RESET = 7'h20;   // 32 quarter seconds = eight seconds
    localparam logic [6:0] CAL_IVL_MIN = 7'h01;
    localparam int NUM_TIMERS = 8;
    localparam int TICK_W = 31;
    localparam int TMO_W = 16;
    // Calibration scheduler states, Gray coded along wait -> run -> wait
    typedef enum logic [1:0] {
        LFCT_CAL_WAIT = 2'b00,
        LFCT_CAL_RUN = 2'b01
    } lfct_cal_state_t;
endpackage

// [src/lfct_timer.sv]
// Purpose: One timeout timer counting in timer-unit steps of two base units
// Assumes: step is a one-cycle enable, one per timer unit
// Notes: A start while running reloads the count
`timescale 1ns/1ns
module lfct_timer
    import lfct_pkg::*;
#(
    parameter int W = TMO_W
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic step,
    input wire logic start,
    input wire logic stop,
    input wire logic [W-1:0] load,
    output logic running,
    output logic expired
);
    logic [W-1:0] count;
    logic [W-1:0] next_count;
    logic next_running;
    logic next_expired;

    // Count down one per unit; the event fires on reaching zero
    always_comb begin
        next_count = count;
        next_running = running;
        next_expired = 1'b0;
        if (start) begin
            next_count = (load == '0) ? W'(1) : load;
            next_running = 1'b1;
        end else if (stop) begin
            next_running = 1'b0;
        end else if (running && step) begin
            next_count = count - W'(1);
            if (count == W'(1)) begin
                next_running = 1'b0;
                next_expired = 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            count <= '0;
            running <= 1'b0;
            expired <= 1'b0;
        end else begin
            count <= next_count;
            running <= next_running;
            expired <= next_expired;
        end
    end
endmodule

// [src/lfct_top.sv]
// Purpose: Oscillator calibration scheduler, eight timeout timers and a tick counter
// Assumes: Single core_clk; the oscillator tick is modelled by a divider enable
// Notes: Calibration interval is a 7-bit count of quarter seconds
`timescale 1ns/1ns
module lfct_top
    import lfct_pkg::*;
#(
    parameter int CAL_RUN_CYCLES = CAL_RUN_CYC,
    parameter int QSEC_CYCLES = QSEC_CYC,
    parameter int LF_CYCLES = LF_TICK_CYC,
    parameter int NT = NUM_TIMERS
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic cal_ivl_wr,
    input wire logic [6:0] cal_ivl_data,
    output logic cal_ivl_err,
    output logic [6:0] cal_ivl,
    output logic cal_busy,
    output logic cal_done,
    input wire logic [NT-1:0] tmr_start,
    input wire logic [NT-1:0] tmr_stop,
    input wire logic [NT*TMO_W-1:0] tmr_load,
    output logic [NT-1:0] tmr_running,
    output logic [NT-1:0] tmr_event,
    output logic [TICK_W-1:0] tick_count
);
    // Code 0 is off the grid; every other 7-bit value is a legal quarter step
    function automatic logic ivl_ok(input logic [6:0] v);
        ivl_ok = (v >= CAL_IVL_MIN);
    endfunction

    logic [31:0] lf_div;
    logic [31:0] next_lf_div;
    logic lf_tick;
    logic [4:0] base_div;
    logic [4:0] next_base_div;
    logic base_tick;
    logic [0:0] unit_div;
    logic [0:0] next_unit_div;
    logic unit_tick;
    logic [TICK_W-1:0] next_tick_count;

    // Oscillator tick divider, then 16 ticks per 488 us base unit
    always_comb begin
        lf_tick = (lf_div == 32'(LF_CYCLES - 1));
        next_lf_div = lf_tick ? 32'h0000_0000 : lf_div + 32'h0000_0001;
        base_tick = lf_tick && (base_div == 5'(BASE_LF_TICKS - 1));
        next_base_div = base_div;
        if (lf_tick) begin
            next_base_div = base_tick ? 5'h00 : base_div + 5'h01;
        end
        unit_tick = base_tick && (unit_div == 1'(MS_BASE_UNITS - 1));
        next_unit_div = unit_div;
        if (base_tick) begin
            next_unit_div = unit_tick ? 1'b0 : unit_div + 1'b1;
        end
        // Free running; wraps at 2^31 with no stop
        next_tick_count = unit_tick ? tick_count + TICK_W'(1) : tick_count;
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            lf_div <= 32'h0000_0000;
            base_div <= 5'h00;
            unit_div <= 1'b0;
            tick_count <= '0;
        end else begin
            lf_div <= next_lf_div;
            base_div <= next_base_div;
            unit_div <= next_unit_div;
            tick_count <= next_tick_count;
        end
    end

    // Eight timers, all stepped from the same unit enable
    genvar gi;
    generate
        for (gi = 0; gi < NT; gi++) begin : g_tmr
            lfct_timer #(.W(TMO_W)) u_tmr (
                .core_clk(core_clk),
                .rst(rst),
                .step(unit_tick),
                .start(tmr_start[gi]),
                .stop(tmr_stop[gi]),
                .load(tmr_load[gi*TMO_W +: TMO_W]),
                .running(tmr_running[gi]),
                .expired(tmr_event[gi])
            );
        end
    endgenerate

    // Calibration scheduler
    lfct_cal_state_t cal_state;
    lfct_cal_state_t next_cal_state;
    logic [31:0] qsec_cnt;
    logic [31:0] next_qsec_cnt;
    logic [6:0] ivl_cnt;
    logic [6:0] next_ivl_cnt;
    logic [31:0] run_cnt;
    logic [31:0] next_run_cnt;
    logic [6:0] next_cal_ivl;
    logic next_cal_ivl_err;
    logic next_cal_done;
    logic qsec_tick;

    always_comb begin
        qsec_tick = (qsec_cnt == 32'(QSEC_CYCLES - 1));
        next_qsec_cnt = qsec_tick ? 32'h0000_0000 : qsec_cnt + 32'h0000_0001;
        next_cal_ivl = cal_ivl;
        next_cal_ivl_err = 1'b0;
        // Illegal codes are refused and leave the interval unchanged
        if (cal_ivl_wr) begin
            if (ivl_ok(cal_ivl_data)) begin
                next_cal_ivl = cal_ivl_data;
            end else begin
                next_cal_ivl_err = 1'b1;
            end
        end
        next_cal_state = cal_state;
        next_ivl_cnt = ivl_cnt;
        next_run_cnt = run_cnt;
        next_cal_done = 1'b0;
        case (cal_state)
            LFCT_CAL_WAIT: begin
                if (qsec_tick) begin
                    next_ivl_cnt = ivl_cnt + 7'h01;
                    // Compare against the live setting so a shorter new interval takes effect promptly
                    if (ivl_cnt + 7'h01 >= cal_ivl) begin
                        next_ivl_cnt = 7'h00;
                        next_run_cnt = 32'h0000_0000;
                        next_cal_state = LFCT_CAL_RUN;
                    end
                end
            end
            LFCT_CAL_RUN: begin
                next_run_cnt = run_cnt + 32'h0000_0001;
                if (run_cnt == 32'(CAL_RUN_CYCLES - 1)) begin
                    next_cal_done = 1'b1;
                    next_cal_state = LFCT_CAL_WAIT;
                end
            end
            default: begin
                next_cal_state = LFCT_CAL_WAIT;
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            cal_state <= LFCT_CAL_WAIT;
            qsec_cnt <= 32'h0000_0000;
            ivl_cnt <= 7'h00;
            run_cnt <= 32'h0000_0000;
            cal_ivl <= CAL_IVL_RESET;
            cal_ivl_err <= 1'b0;
            cal_done <= 1'b0;
        end else begin
            cal_state <= next_cal_state;
            qsec_cnt <= next_qsec_cnt;
            ivl_cnt <= next_ivl_cnt;
            run_cnt <= next_run_cnt;
            cal_ivl <= next_cal_ivl;
            cal_ivl_err <= next_cal_ivl_err;
            cal_done <= next_cal_done;
        end
    end

    assign cal_busy = (cal_state == LFCT_CAL_RUN);

    // Check helper: length of the current busy stretch, counted apart from run_cnt
    // so that the run length check does not lean on the counter it judges
    logic [31:0] busy_len;
    logic [31:0] next_busy_len;

    always_comb begin
        next_busy_len = cal_busy ? busy_len + 32'h0000_0001 : 32'h0000_0000;
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            busy_len <= 32'h0000_0000;
        end else begin
            busy_len <= next_busy_len;
        end
    end

    // Checks
    sequence s_run_start;
        !cal_busy ##1 cal_busy;
    endsequence

    sequence s_run_end;
        cal_busy ##1 !cal_busy;
    endsequence

    chk_reset_ivl: assert property (@(posedge core_clk) $fell(rst) |-> cal_ivl == 7'h20)
        else $error("interval not eight seconds after reset");
    chk_bad_ivl: assert property (@(posedge core_clk) disable iff (rst)
        cal_ivl_wr && cal_ivl_data == 7'h00 |=> cal_ivl_err && cal_ivl == $past(cal_ivl))
        else $error("zero interval accepted");
    chk_good_ivl: assert property (@(posedge core_clk) disable iff (rst)
        cal_ivl_wr && cal_ivl_data != 7'h00 |=> cal_ivl == $past(cal_ivl_data))
        else $error("legal interval not stored");
    chk_run_len: assert property (@(posedge core_clk) disable iff (rst)
        s_run_end |-> cal_done && busy_len == 32'(CAL_RUN_CYCLES))
        else $error("calibration run length wrong");
    chk_run_start: assert property (@(posedge core_clk) disable iff (rst)
        s_run_start |-> $past(qsec_tick))
        else $error("run began off a quarter-second step");
    chk_done_idle: assert property (@(posedge core_clk) disable iff (rst)
        cal_done |-> !cal_busy && $past(cal_busy))
        else $error("done without run");
    chk_tick_step: assert property (@(posedge core_clk) disable iff (rst)
        unit_tick |=> tick_count == $past(tick_count) + 31'h0000_0001)
        else $error("tick counter missed a step");
    chk_tick_hold: assert property (@(posedge core_clk) disable iff (rst)
        !unit_tick |=> $stable(tick_count))
        else $error("tick counter moved off the base");
    chk_tmr_event: assert property (@(posedge core_clk) disable iff (rst)
        |tmr_event |-> $past(unit_tick) && ((tmr_event & ~$past(tmr_running)) == '0))
        else $error("timeout event without a running timer");
endmodule

// [verif/lfct_top_tb_top.sv]
// Purpose: Self-checking bench for the calibration scheduler, timeout timers and tick counter
// Assumes: Shortened counts (run 5, quarter 10, oscillator tick 2 cycles); inputs move on the falling edge
// Notes: The tick counter wrap needs 2^31 units, too long to reach here
`timescale 1ns/1ns
module lfct_top_tb_top;
    import lfct_pkg::*;
    // Run kept shorter than a quarter, as with the real timing, so no quarter step falls inside a run
    localparam int RUN = 5;
    localparam int QS = 10;
    localparam int LF = 2;
    localparam int UNIT = LF * BASE_LF_TICKS * TMO_BASE_UNITS;
    logic core_clk, rst, cal_ivl_wr, cal_ivl_err, cal_busy, cal_done;
    logic [6:0] cal_ivl_data, cal_ivl;
    logic [7:0] tmr_start, tmr_stop, tmr_running, tmr_event;
    logic [NUM_TIMERS*TMO_W-1:0] tmr_load;
    logic [TICK_W-1:0] tick_count;
    int mismatches = 0;
    int num_checks = 0;
    lfct_top #(.CAL_RUN_CYCLES(RUN), .QSEC_CYCLES(QS), .LF_CYCLES(LF), .NT(NUM_TIMERS)) dut (
        .core_clk(core_clk), .rst(rst), .cal_ivl_wr(cal_ivl_wr), .cal_ivl_data(cal_ivl_data),
        .cal_ivl_err(cal_ivl_err), .cal_ivl(cal_ivl), .cal_busy(cal_busy), .cal_done(cal_done),
        .tmr_start(tmr_start), .tmr_stop(tmr_stop), .tmr_load(tmr_load), .tmr_running(tmr_running),
        .tmr_event(tmr_event), .tick_count(tick_count));
    // Free-running 100 MHz clock
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    task automatic tick(input int n);
        repeat (n) @(negedge core_clk);
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %s exp %0h got %0h", what, exp, got);
        end
    endtask
    // Counts cycles until busy reaches the wanted level, bounded so a stuck state cannot hang
    task automatic wait_busy(input logic lvl, output int n);
        n = 0;
        while (cal_busy !== lvl && n < 2000) begin
            tick(1);
            n++;
        end
    endtask
    task automatic wr(input logic [6:0] v);
        cal_ivl_wr = 1'b1;
        cal_ivl_data = v;
        tick(1);
        cal_ivl_wr = 1'b0;
    endtask
    task automatic pulse(input logic [7:0] st, input logic [7:0] sp);
        tmr_start = st;
        tmr_stop = sp;
        tick(1);
        tmr_start = 8'h00;
        tmr_stop = 8'h00;
    endtask
    // Reset state, then the default interval and one run length
    task automatic t_cal_default();
        int n;
        chk("ivl reset", 32'h0000_0020, 32'(cal_ivl));
        chk("idle outs", 32'h0000_0000, 32'({cal_busy, cal_done, tmr_running, tmr_event}));
        chk("tick reset", 32'h0000_0000, 32'(tick_count));
        wait_busy(1'b1, n);
        chk("first run", 1, 32'(n >= 31 * QS && n <= 33 * QS));
        wait_busy(1'b0, n);
        chk("run len", RUN, n);
        chk("done", 1, 32'(cal_done));
        tick(1);
        chk("done pulse", 0, 32'(cal_done));
    endtask
    // Edge codes, a refused code and the rescaled period
    task automatic t_ivl();
        int n;
        wr(7'h7f);
        chk("ivl max", 32'h0000_007f, 32'(cal_ivl));
        tick(1);
        wr(7'h01);
        chk("ivl min", 32'h0000_0001, 32'(cal_ivl));
        tick(1);
        wr(7'h00);
        chk("err", 1, 32'(cal_ivl_err));
        chk("ivl kept", 32'h0000_0001, 32'(cal_ivl));
        tick(1);
        chk("err pulse", 0, 32'(cal_ivl_err));
        wr(7'h04);
        chk("ivl 4", 32'h0000_0004, 32'(cal_ivl));
        chk("no err", 0, 32'(cal_ivl_err));
        wait_busy(1'b0, n);
        wait_busy(1'b1, n);
        wait_busy(1'b0, n);
        wait_busy(1'b1, n);
        chk("period", 1, 32'(n + RUN >= 4 * QS - 1 && n + RUN <= 4 * QS + 1));
    endtask
    // Each timer alone, with its own load, expires in the right unit
    task automatic t_timers();
        int n;
        for (int i = 0; i < NUM_TIMERS; i++) begin
            tmr_load = (NUM_TIMERS * TMO_W)'(i + 1) << (TMO_W * i);
            pulse(8'h01 << i, 8'h00);
            chk("run", 32'(8'h01 << i), 32'(tmr_running));
            n = 0;
            while (tmr_event === 8'h00 && n < 20 * UNIT) begin
                tick(1);
                n++;
            end
            chk("tmo", 1, 32'(n >= i * UNIT && n <= (i + 1) * UNIT + 1));
            chk("evt", 32'h0000_0100 << i, 32'({tmr_event, tmr_running}));
            tick(1);
            chk("evt pulse", 0, 32'(tmr_event));
        end
    endtask
    // Common source, stop, start winning over stop, zero load
    task automatic t_ctrl();
        int n;
        tmr_load = {NUM_TIMERS{16'h0002}};
        pulse(8'hff, 8'h00);
        n = 0;
        while (tmr_event === 8'h00 && n < 4 * UNIT) begin
            tick(1);
            n++;
        end
        chk("shared", 32'h0000_00ff, 32'(tmr_event));
        tmr_load = '0;
        pulse(8'h02, 8'h00);
        tick(UNIT + 1);
        chk("zero load", 0, 32'(tmr_running[1]));
        tmr_load = {NUM_TIMERS{16'h0005}};
        pulse(8'h0c, 8'h08);
        chk("start wins", 32'h0000_000c, 32'(tmr_running));
        tick(5);
        pulse(8'h00, 8'h0c);
        chk("stopped", 0, 32'(tmr_running));
        n = 0;
        repeat (6 * UNIT) begin
            tick(1);
            n += (tmr_event !== 8'h00);
        end
        chk("no evt", 0, n);
    endtask
    // Tick counter advances once per timer unit
    task automatic t_tick();
        logic [TICK_W-1:0] a;
        a = tick_count;
        tick(4 * UNIT);
        chk("tick rate", 4, 32'(tick_count - a));
    endtask
    task automatic wrap_up();
        if (mismatches == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // Main sequence
    initial begin
        rst = 1'b1;
        cal_ivl_wr = 1'b0;
        cal_ivl_data = 7'h00;
        tmr_start = 8'h00;
        tmr_stop = 8'h00;
        tmr_load = '0;
        tick(20);
        rst = 1'b0;
        tick(1);
        t_cal_default();
        t_ivl();
        t_timers();
        t_ctrl();
        t_tick();
        wrap_up();
    end
    // Watchdog: the sequence needs about 3500 cycles
    initial begin
        tick(50000);
        mismatches++;
        wrap_up();
    end
endmodule
